// ### msc_regs.svh
// register map, reset values and timing constants of the scrub counters
`ifndef MSC_REGS_SVH
`define MSC_REGS_SVH

// register byte addresses
`define MSC_DIV_LOW_ADDR 32'hfff43040
`define MSC_TIMER_HIGH_ADDR 32'hfff43044
`define MSC_TIMER_LOW_ADDR 32'hfff43048
`define MSC_ADDR_TOP_ADDR 32'hfff4304c
`define MSC_ADDR_UPPER_ADDR 32'hfff43050
`define MSC_ADDR_MID_ADDR 32'hfff43054
`define MSC_ADDR_LOW_ADDR 32'hfff43058
`define MSC_CTRL_ADDR 32'hfff43080
`define MSC_INTERVAL_ADDR 32'hfff43084
`define MSC_TICKDIV_ADDR 32'hfff43088

// control register field positions
`define MSC_CTRL_EN_BIT 0
`define MSC_CTRL_BUSY_BIT 1

// reset values
`define MSC_DIV_RESET 22'h000000
`define MSC_TIMER_RESET 16'h0000
`define MSC_WALK_RESET 23'h000000
`define MSC_INTERVAL_RESET 16'hffff
`define MSC_CTRL_EN_RESET 1'b0

// timing: bus clock rate, fast tick rate, slow tick period in seconds
`define MSC_PCLK_HZ 25000000
`define MSC_FAST_TICK_HZ 1000000
`define MSC_SLOW_TICK_PERIOD_S 2

// smallest memory walk, in 16-byte scrub units (4 MB)
`define MSC_SIZE_BASE_UNITS 24'h040000
`define MSC_SIZE_CODE_MAX 3'h5

`endif

// ### msc_pkg.sv
// types shared by the scrub counter design
package msc_pkg;

    // memory walk state
    typedef enum logic [0:0] {
        MSC_IDLE = 1'b0,
        MSC_WALK = 1'b1
    } msc_state_t;

    // scrub walk output bundle
    typedef struct packed {
        logic busy;
        logic start;
        logic [26:0] addr;
    } msc_walk_t;

endpackage

// ### msc_tick_div.sv
// chip prescaler: turns the bus clock into a 1 MHz tick pulse
`timescale 1ns/1ps
`default_nettype none

module msc_tick_div (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] div_value,
    output logic tick
);

    logic [7:0] cnt_reg; // bus clocks since last tick
    logic tick_reg; // registered tick pulse
    logic cnt_last; // last clock of one fast period

    // a value of 0 or 1 gives a tick every clock
    assign cnt_last = ({1'b0, cnt_reg} + 9'h001) >= {1'b0, div_value};
    assign tick = tick_reg;

    // count bus clocks and pulse once per programmed period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_last ? 8'h00 : cnt_reg + 8'h01;
            tick_reg <= cnt_last;
        end
    end

    // tick follows the last count of each period, and only it
    fast_tick_a: assert property (@(posedge pclk) disable iff (!presetn) cnt_last |=> tick_reg)
        else $error("fast tick missing after last count");
    fast_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!cnt_last && div_value > 8'h01) |=> !tick_reg)
        else $error("fast tick outside period end");

endmodule

`default_nettype wire

// ### msc_scrub_counters.sv
// scrub prescaler, scrub interval timer and scrub walk address counter with apb access
//
// Contract
// - divider low byte reads live, writes load
// - timer steps every two seconds when running
// - timer clears on matching interval, keeps counting
// - timer bytes writable, reads return present count
// - timer 16 bits, high and low bytes
// - walk address steps per scrub cycle
// - each pass walks zero up to size
// - walk address bytes writable, reads return count
// - top byte carries bits 26-24 low
// - low byte bits 7-4, low nibble zero
// - divider turns 1 MHz into 0.5 Hz
// - pass spacing is two seconds times interval
// - 1 MHz tick from bus clock, programmed
`include "msc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module msc_scrub_counters
    import msc_pkg::*;
#(
    parameter int SLOW_DIV_TICKS = `MSC_SLOW_TICK_PERIOD_S * `MSC_FAST_TICK_HZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] dram_size_pins,
    input wire logic scrub_cycle_done,
    output var msc_walk_t walk_out
);

    // fast tick divide value derived from the clock rates
    localparam logic [7:0] TICKDIV_RESET = 8'(`MSC_PCLK_HZ / `MSC_FAST_TICK_HZ);
    // last value of the slow divider before it wraps
    localparam logic [21:0] SLOW_DIV_LAST = 22'(SLOW_DIV_TICKS - 1);

    // apb answer registers
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    // software settings
    logic ctrl_en_reg; // scrub_enable_bit
    logic [15:0] interval_reg; // scrub_interval_setting
    logic [7:0] tickdiv_reg; // bus clocks per fast tick
    // counters
    logic [21:0] div_cnt_reg; // scrub_divider_count
    logic slow_tick_reg; // 0.5 Hz pulse
    logic [15:0] timer_reg; // scrub_interval_timer
    logic [22:0] walk_cnt_reg; // scrub_walk_address bits 26-4
    msc_state_t state_reg;
    msc_state_t state_next;
    msc_walk_t walk_out_reg;
    // dram_size_pins synchroniser and settled code
    logic [2:0] size_s1_reg;
    logic [2:0] size_s2_reg;
    logic [2:0] size_s3_reg;
    logic [2:0] size_code_reg;
    // fast tick from the chip prescaler
    logic fast_tick;

    // last scrub unit of the memory for a size code, larger codes clamp
    function automatic logic [22:0] msc_size_last(input logic [2:0] code);
        logic [2:0] c;
        logic [23:0] units;
        c = (code > `MSC_SIZE_CODE_MAX) ? `MSC_SIZE_CODE_MAX : code;
        units = `MSC_SIZE_BASE_UNITS << c;
        msc_size_last = 23'(units - 24'h000001);
    endfunction

    // chip prescaler instance
    msc_tick_div u_tick_div (
        .pclk(pclk),
        .presetn(presetn),
        .div_value(tickdiv_reg),
        .tick(fast_tick)
    );

    // address decode
    wire sel_div_low = paddr == `MSC_DIV_LOW_ADDR;
    wire sel_timer_high = paddr == `MSC_TIMER_HIGH_ADDR;
    wire sel_timer_low = paddr == `MSC_TIMER_LOW_ADDR;
    wire sel_addr_top = paddr == `MSC_ADDR_TOP_ADDR;
    wire sel_addr_upper = paddr == `MSC_ADDR_UPPER_ADDR;
    wire sel_addr_mid = paddr == `MSC_ADDR_MID_ADDR;
    wire sel_addr_low = paddr == `MSC_ADDR_LOW_ADDR;
    wire sel_ctrl = paddr == `MSC_CTRL_ADDR;
    wire sel_interval = paddr == `MSC_INTERVAL_ADDR;
    wire sel_tickdiv = paddr == `MSC_TICKDIV_ADDR;
    wire sel_hit = sel_div_low | sel_timer_high | sel_timer_low | sel_addr_top | sel_addr_upper
        | sel_addr_mid | sel_addr_low | sel_ctrl | sel_interval | sel_tickdiv;

    // apb phases: answer in the first access cycle
    wire apb_setup = psel & ~penable;
    wire apb_wr = psel & penable & pwrite & pready_reg;
    wire wr_div_low = apb_wr & sel_div_low;
    wire wr_timer_high = apb_wr & sel_timer_high;
    wire wr_timer_low = apb_wr & sel_timer_low;
    wire wr_timer_any = wr_timer_high | wr_timer_low;
    wire wr_addr_top = apb_wr & sel_addr_top;
    wire wr_addr_upper = apb_wr & sel_addr_upper;
    wire wr_addr_mid = apb_wr & sel_addr_mid;
    wire wr_addr_low = apb_wr & sel_addr_low;
    wire wr_addr_any = wr_addr_top | wr_addr_upper | wr_addr_mid | wr_addr_low;

    // read data selection, unused bits read zero
    wire [31:0] rd_mux = sel_div_low ? {24'h000000, div_cnt_reg[7:0]} :
        sel_timer_high ? {24'h000000, timer_reg[15:8]} :
        sel_timer_low ? {24'h000000, timer_reg[7:0]} :
        sel_addr_top ? {29'h00000000, walk_cnt_reg[22:20]} :
        sel_addr_upper ? {24'h000000, walk_cnt_reg[19:12]} :
        sel_addr_mid ? {24'h000000, walk_cnt_reg[11:4]} :
        sel_addr_low ? {24'h000000, walk_cnt_reg[3:0], 4'h0} :
        sel_ctrl ? {30'h00000000, walk_out_reg.busy, ctrl_en_reg} :
        sel_interval ? {16'h0000, interval_reg} :
        sel_tickdiv ? {24'h000000, tickdiv_reg} : 32'h00000000;

    // slow divider: counts fast ticks, wraps to give the 0.5 Hz pulse
    wire div_wrap = fast_tick & (div_cnt_reg >= SLOW_DIV_LAST);
    wire slow_tick_next = div_wrap & ~wr_div_low;

    // interval timer steering
    wire timer_run = ctrl_en_reg & (interval_reg != 16'h0000);
    wire [15:0] timer_inc = timer_reg + 16'h0001;
    wire timer_match = slow_tick_reg & timer_run & (timer_inc == interval_reg);
    wire pass_start = timer_match & ~wr_timer_any;

    // walk counter steering
    wire [22:0] size_last = msc_size_last(size_code_reg);
    wire walk_last = walk_cnt_reg >= size_last;
    wire walk_step = (state_reg == MSC_WALK) & scrub_cycle_done;
    wire walk_begin = pass_start & (state_reg == MSC_IDLE) & ~wr_addr_any;
    wire walk_finish = walk_step & walk_last & ~wr_addr_any;
    wire [22:0] walk_cnt_next = wr_addr_top ? {pwdata[2:0], walk_cnt_reg[19:0]} :
        wr_addr_upper ? {walk_cnt_reg[22:20], pwdata[7:0], walk_cnt_reg[11:0]} :
        wr_addr_mid ? {walk_cnt_reg[22:12], pwdata[7:0], walk_cnt_reg[3:0]} :
        wr_addr_low ? {walk_cnt_reg[22:4], pwdata[7:4]} :
        walk_begin ? 23'h000000 :
        walk_step ? (walk_last ? 23'h000000 : walk_cnt_reg + 23'h000001) : walk_cnt_reg;

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign walk_out = walk_out_reg;

    // apb slave: latch read data in setup, answer in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (apb_setup) begin
            prdata_reg <= pwrite ? 32'h00000000 : rd_mux;
            pready_reg <= 1'b1;
            pslverr_reg <= ~sel_hit; // unmapped address
        end else begin
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // software settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_reg <= `MSC_CTRL_EN_RESET;
            interval_reg <= `MSC_INTERVAL_RESET;
            tickdiv_reg <= TICKDIV_RESET;
        end else if (apb_wr) begin
            if (sel_ctrl) begin
                ctrl_en_reg <= pwdata[`MSC_CTRL_EN_BIT];
            end
            if (sel_interval) begin
                interval_reg <= pwdata[15:0];
            end
            if (sel_tickdiv) begin
                tickdiv_reg <= pwdata[7:0];
            end
        end
    end

    // slow divider count and its output pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= `MSC_DIV_RESET;
            slow_tick_reg <= 1'b0;
        end else begin
            if (wr_div_low) begin
                div_cnt_reg <= {div_cnt_reg[21:8], pwdata[7:0]};
            end else if (fast_tick) begin
                div_cnt_reg <= div_wrap ? 22'h000000 : div_cnt_reg + 22'h000001;
            end
            slow_tick_reg <= slow_tick_next;
        end
    end

    // interval timer: software write wins over counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_reg <= `MSC_TIMER_RESET;
        end else if (wr_timer_high) begin
            timer_reg <= {pwdata[7:0], timer_reg[7:0]};
        end else if (wr_timer_low) begin
            timer_reg <= {timer_reg[15:8], pwdata[7:0]};
        end else if (slow_tick_reg & timer_run) begin
            timer_reg <= timer_match ? 16'h0000 : timer_inc;
        end
    end

    // walk state selection
    always_comb begin
        case (state_reg)
            MSC_IDLE: begin
                state_next = walk_begin ? MSC_WALK : MSC_IDLE;
            end
            MSC_WALK: begin
                state_next = walk_finish ? MSC_IDLE : MSC_WALK;
            end
            default: begin
                state_next = MSC_IDLE;
            end
        endcase
    end

    // walk counter, state and output bundle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            walk_cnt_reg <= `MSC_WALK_RESET;
            state_reg <= MSC_IDLE;
            walk_out_reg <= '0;
        end else begin
            walk_cnt_reg <= walk_cnt_next;
            state_reg <= state_next;
            walk_out_reg.busy <= state_next == MSC_WALK;
            walk_out_reg.start <= walk_begin;
            walk_out_reg.addr <= {walk_cnt_next, 4'h0};
        end
    end

    // dram_size_pins: three stages, code settles when the last two agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            size_s1_reg <= 3'h0;
            size_s2_reg <= 3'h0;
            size_s3_reg <= 3'h0;
            size_code_reg <= 3'h0;
        end else begin
            size_s1_reg <= dram_size_pins;
            size_s2_reg <= size_s1_reg;
            size_s3_reg <= size_s2_reg;
            if (size_s2_reg == size_s3_reg) begin
                size_code_reg <= size_s3_reg;
            end
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // setup cycle of a read to one register
    sequence rd_setup(logic hit);
        psel && !penable && !pwrite && hit;
    endsequence

    // access cycle of a write to one register
    sequence wr_access(logic hit);
        psel && penable && pwrite && pready_reg && hit;
    endsequence

    div_low_read_a: assert property (rd_setup(sel_div_low) |=> prdata == {24'h000000, $past(div_cnt_reg[7:0])})
        else $error("divider low byte read wrong");
    div_low_write_a: assert property (wr_access(sel_div_low) |=> div_cnt_reg[7:0] == $past(pwdata[7:0]))
        else $error("divider low byte write lost");
    slow_tick_gen_a: assert property (fast_tick && div_cnt_reg == SLOW_DIV_LAST && !wr_div_low
        |=> slow_tick_reg && div_cnt_reg == 22'h000000)
        else $error("slow tick not made at divider wrap");
    timer_step_a: assert property (slow_tick_reg && timer_run && !wr_timer_any && timer_inc != interval_reg
        |=> timer_reg == $past(timer_inc))
        else $error("timer did not step");
    timer_wrap_a: assert property (timer_match && !wr_timer_any |=> timer_reg == 16'h0000 ##1 !walk_out_reg.start)
        else $error("timer did not clear on match");
    timer_hold_a: assert property (!timer_run && !wr_timer_any |=> $stable(timer_reg))
        else $error("timer moved while stopped");
    timer_high_a: assert property (rd_setup(sel_timer_high) |=> prdata[7:0] == $past(timer_reg[15:8]))
        else $error("timer high byte read wrong");
    timer_write_a: assert property (wr_access(sel_timer_low) |=> timer_reg[7:0] == $past(pwdata[7:0]))
        else $error("timer low byte write lost");
    walk_step_a: assert property (walk_step && !walk_last && !wr_addr_any
        |=> walk_cnt_reg == $past(walk_cnt_reg) + 23'h000001)
        else $error("walk address did not step");
    walk_pass_a: assert property (walk_begin |=> walk_out_reg.start && walk_out_reg.busy
        && walk_out_reg.addr == 27'h0000000)
        else $error("pass did not start at zero");
    walk_end_a: assert property (walk_finish |=> state_reg == MSC_IDLE && walk_cnt_reg == 23'h000000)
        else $error("pass did not end at size");
    addr_write_a: assert property (wr_access(sel_addr_mid) |=> walk_cnt_reg[11:4] == $past(pwdata[7:0]))
        else $error("walk mid byte write lost");
    addr_top_a: assert property (rd_setup(sel_addr_top)
        |=> prdata[31:3] == 29'h00000000 && prdata[2:0] == $past(walk_cnt_reg[22:20]))
        else $error("walk top byte read wrong");
    addr_low_a: assert property (rd_setup(sel_addr_low)
        |=> prdata[3:0] == 4'h0 && prdata[7:4] == $past(walk_cnt_reg[3:0]))
        else $error("walk low byte read wrong");

endmodule

`default_nettype wire

// ### msc_mem_model.sv
// memory-side model: answers a scrub pass with paced memory-cycle pulses
`timescale 1ns/1ps
`default_nettype none

module msc_mem_model #(
    parameter int GAP = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic busy,
    input wire logic stall,
    output logic done
);
    int gap_cnt; // clocks since the last memory cycle

    // one memory cycle every GAP clocks while a pass runs and no stall is asked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_cnt <= 0;
            done <= 1'b0;
        end else if (busy && !stall && gap_cnt == GAP - 1) begin
            gap_cnt <= 0;
            done <= 1'b1;
        end else begin
            gap_cnt <= (busy && !stall) ? gap_cnt + 1 : 0;
            done <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### tb_top.sv
// testbench for the scrub counters: apb access, timer pacing and memory walk
`include "msc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import msc_pkg::*;
;
    localparam int SLOW = 8; // fast ticks per slow tick, shortened
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic pready, pslverr, done;
    logic stall = 1'b1; // memory side held off until a scenario lets it run
    logic [2:0] size_code = 3'h0;
    msc_walk_t walk_out;
    int err_total = 0, n_checks = 0, done_cnt = 0;
    realtime t_a, t_b;
    // byte registers and what reads back after writing them
    logic [31:0] rw_a [6] = '{`MSC_TIMER_HIGH_ADDR, `MSC_TIMER_LOW_ADDR, `MSC_ADDR_TOP_ADDR,
        `MSC_ADDR_UPPER_ADDR, `MSC_ADDR_MID_ADDR, `MSC_ADDR_LOW_ADDR};
    logic [7:0] rw_e [6] = '{8'ha5, 8'h3c, 8'h07, 8'hff, 8'hff, 8'hf0};

    // 25 MHz bus clock
    always #20 pclk = ~pclk;

    msc_scrub_counters #(.SLOW_DIV_TICKS(SLOW)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dram_size_pins(size_code), .scrub_cycle_done(done),
        .walk_out(walk_out));
    msc_mem_model #(.GAP(3)) mem_u (.pclk(pclk), .presetn(presetn), .busy(walk_out.busy),
        .stall(stall), .done(done));

    // memory cycles the walk counter should have taken
    always @(posedge pclk) if (done && walk_out.busy) done_cnt <= done_cnt + 1;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // one apb transfer, held until pready, then one idle clock
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        int n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1) chk(32'h0, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask

    // wait for a pass to begin; it must begin at walk address zero
    task automatic wait_start(output realtime t);
        int n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (walk_out.start !== 1'b1 && n < 2000);
        t = $realtime;
        chk({5'h0, walk_out.addr}, 32'h0);
        chk({31'h0, walk_out.busy & (n < 2000)}, 32'h1);
    endtask

    // memory side stalled: move the walk to its last unit, then let one cycle finish the pass
    task automatic end_pass(input logic [7:0] top, input logic [7:0] up);
        int n = 0;
        wr(`MSC_ADDR_LOW_ADDR, 32'hf0);
        wr(`MSC_ADDR_MID_ADDR, 32'hff);
        wr(`MSC_ADDR_UPPER_ADDR, {24'h0, up});
        wr(`MSC_ADDR_TOP_ADDR, {24'h0, top});
        stall <= 1'b0;
        do begin
            @(posedge pclk);
            n++;
        end while (walk_out.busy !== 1'b0 && n < 100);
        stall <= 1'b1;
        chk({4'h0, n < 100, walk_out.addr}, 32'h8000000);
    endtask

    task automatic t_reset;
        logic [31:0] v;
        logic e;
        rd(`MSC_DIV_LOW_ADDR, v);
        chk(v, 32'h0);
        for (int i = 0; i < 6; i++) begin
            rd(rw_a[i], v);
            chk(v, 32'h0);
        end
        rd(`MSC_INTERVAL_ADDR, v);
        chk(v, 32'hffff);
        rd(`MSC_TICKDIV_ADDR, v);
        chk(v, 32'h19);
        apb(1'b0, 32'hfff43060, 32'h0, v, e);
        chk({v[30:0], e}, 32'h1);
        $display("test reset values done");
    endtask

    task automatic t_rw;
        logic [31:0] v;
        for (int i = 0; i < 6; i++) begin
            wr(rw_a[i], (i < 2) ? {24'h0, rw_e[i]} : 32'hff);
            rd(rw_a[i], v);
            chk(v, {24'h0, rw_e[i]});
        end
        $display("test register access done");
    endtask

    task automatic t_div;
        logic [31:0] v;
        wr(`MSC_TICKDIV_ADDR, 32'hff);
        wr(`MSC_DIV_LOW_ADDR, 32'h5);
        rd(`MSC_DIV_LOW_ADDR, v);
        chk({31'h0, (v === 32'h5) || (v === 32'h6)}, 32'h1);
        wr(`MSC_TICKDIV_ADDR, 32'h1);
        repeat (5) @(posedge pclk);
        rd(`MSC_DIV_LOW_ADDR, v);
        chk({31'h0, v < SLOW}, 32'h1);
        // with a fast tick every clock the divider must move by exactly one between write and read
        wr(`MSC_DIV_LOW_ADDR, 32'h0);
        rd(`MSC_DIV_LOW_ADDR, v);
        chk(v, 32'h1);
        $display("test divider done");
    endtask

    task automatic t_hold;
        logic [31:0] v;
        wr(`MSC_TIMER_HIGH_ADDR, 32'h0);
        wr(`MSC_TIMER_LOW_ADDR, 32'h5);
        repeat (4 * SLOW) @(posedge pclk);
        rd(`MSC_TIMER_LOW_ADDR, v);
        chk(v, 32'h5);
        wr(`MSC_INTERVAL_ADDR, 32'h0);
        wr(`MSC_CTRL_ADDR, 32'h1);
        repeat (4 * SLOW) @(posedge pclk);
        rd(`MSC_TIMER_LOW_ADDR, v);
        chk(v, 32'h5);
        wr(`MSC_INTERVAL_ADDR, 32'h10);
        repeat (30) @(posedge pclk);
        rd(`MSC_TIMER_LOW_ADDR, v);
        chk({31'h0, (v === 32'h8) || (v === 32'h9)}, 32'h1);
        $display("test timer hold and step done");
    endtask

    task automatic t_walk;
        logic [31:0] v;
        int base_cnt; // memory cycles counted before this pass
        wr(`MSC_TIMER_LOW_ADDR, 32'h0);
        wr(`MSC_INTERVAL_ADDR, 32'h3);
        wait_start(t_a);
        base_cnt = done_cnt;
        stall <= 1'b0;
        repeat (20) @(posedge pclk);
        stall <= 1'b1;
        repeat (4) @(posedge pclk);
        chk({5'h0, walk_out.addr}, 32'((done_cnt - base_cnt) * 16));
        chk({31'h0, (done_cnt - base_cnt) > 4}, 32'h1);
        rd(`MSC_ADDR_LOW_ADDR, v);
        chk(v, 32'(((done_cnt - base_cnt) * 16) % 256));
        end_pass(8'h00, 8'h3f);
        wait_start(t_a);
        end_pass(8'h00, 8'h3f);
        size_code <= 3'h6;
        wait_start(t_b);
        chk(32'(int'((t_b - t_a) / 40.0)), 32'(3 * SLOW));
        end_pass(8'h07, 8'hff);
        // a middle size code: the pass must end at its own last unit
        size_code <= 3'h2;
        wait_start(t_a);
        end_pass(8'h00, 8'hff);
        $display("test memory walk done");
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // reset, then the scenarios in turn
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_rw;
        t_div;
        t_hold;
        t_walk;
        report_and_stop;
    end

    // watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        report_and_stop;
    end
endmodule
`default_nettype wire
